// ### design/hms_pkg.sv
/*
  Package for the homing sequencer: parameter addresses, reset values,
  method codes, speed limits and sequencer states.
  Assumes a parameter port with word addresses as used over the fieldbus.
*/
package hms_pkg;

  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_REF_POS = 16'h1e18;
  localparam logic [15:0] ADDR_EDGE_HOME = 16'h280e;
  localparam logic [15:0] ADDR_EDGE_IDX = 16'h2818;
  localparam logic [15:0] ADDR_POS_SET = 16'h2830;
  localparam logic [15:0] ADDR_METHOD = 16'h2832;
  localparam logic [15:0] ADDR_SEARCH_SPD = 16'h2808;
  localparam logic [15:0] ADDR_LEAVE_SPD = 16'h280a;
  localparam logic [15:0] ADDR_HOME_POS = 16'h2816;
  localparam logic [15:0] ADDR_MAX_RAMP = 16'h2834;
  localparam logic [15:0] ADDR_STATUS = 16'h2836;

  // ----------------------------------------------------------------
  // reset values and ranges
  // ----------------------------------------------------------------
  localparam logic [31:0] EDGE_HOME_RST = 32'h0000_0018;
  localparam logic [31:0] EDGE_HOME_MIN = 32'h0000_0001;
  localparam logic [31:0] EDGE_HOME_MAX = 32'h7fff_ffff;
  localparam logic [15:0] SEARCH_SPD_RST = 16'h0258;
  localparam logic [15:0] SEARCH_SPD_MAX = 16'h3390;
  localparam logic [15:0] LEAVE_SPD_RST = 16'h003c;
  localparam logic [15:0] LEAVE_SPD_MAX = 16'h0bb8;
  localparam logic [15:0] SPD_MIN = 16'h0001;
  localparam logic [15:0] MAX_RAMP_RST = 16'h3390;

  // ----------------------------------------------------------------
  // method codes
  // ----------------------------------------------------------------
  localparam logic [7:0] M_POS_LIMIT_IDX = 8'h02;
  localparam logic [7:0] M_REF_IDX_LO = 8'h0b;
  localparam logic [7:0] M_REF_IDX_HI = 8'h0e;
  localparam logic [7:0] M_NEG_LIMIT = 8'h11;
  localparam logic [7:0] M_REF_DIST_LO = 8'h1b;
  localparam logic [7:0] M_REF_DIST_HI = 8'h1e;
  localparam logic [7:0] M_IDX_NEG = 8'h21;
  localparam logic [7:0] M_IDX_POS = 8'h22;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEARCH = 3'b001,
    ST_RETURN = 3'b010,
    ST_EDGE = 3'b011,
    ST_OFFSET = 3'b100,
    ST_INDEX = 3'b101,
    ST_DONE = 3'b110
  } hms_state_type;

endpackage

// ### design/hms_offset_counter.sv
/*
  Distance counter for the homing sequencer: counts position steps
  after the switching edge. Assumes one step pulse per user unit moved.
*/
module hms_offset_counter (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_step,
  // result
  output logic [31:0] o_count
);

  logic [31:0] count_q;

  always_ff @(posedge i_clock) begin
    if (i_rst || i_clear) begin
      count_q <= 32'h0000_0000;
    end else if (i_step) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  assign o_count = count_q;

endmodule

// ### design/hms_homing_sequencer.sv
/*
  Homing sequencer: drives the motor onto a limit or reference switch,
  finds the switching edge, then moves a set distance or on to the index
  pulse; also index-only homing and position setting.
  Assumes switch inputs already debounced, polarity resolved and
  synchronous; one i_step pulse per user unit moved.
*/
// Summary of operation
// - without index, reach switch then stop at offset from the edge
// - edge distance accepts 1..2147483647, default 24, non-index only
// - method 17 homes on the negative limit switch with offset
// - approach at search speed, edge and final moves at leave speed
// - methods 27..30 home on reference switch with offset
// - overrun through switch range: reverse back in at leave speed
// - reference methods make first search move in negative direction
// - index methods 2 and 11..14 reach switch and edge, then first index pulse
// - read-only edge-to-index distance in 1/10000 revolution
// - method 2 homes positive limit switch, then first index
// - methods 11..14 home reference switch edge, then first index
// - methods 33 and 34 go straight to index at leave speed
// - position set write loads actual position at once
// - position set only at standstill and without scaling
// - position set keeps the following error intact
// - controller reference position readable in user units
// - search speed default 600, range 1..13200, clamped to ramp max
// - after success load home position value as motor position
// - valid zero flag set on success, cleared on loss
module hms_homing_sequencer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // parameter port
  input wire logic i_par_wr,
  input wire logic i_par_rd,
  input wire logic [15:0] i_par_addr,
  input wire logic [31:0] i_par_wdata,
  output logic [31:0] o_par_rdata,
  output logic o_par_ack,
  // control
  input wire logic i_start,
  input wire logic i_ref_lost,
  // switches and encoder
  input wire logic i_positive_limit_input,
  input wire logic i_negative_limit_input,
  input wire logic i_ref_switch,
  input wire logic i_index_pulse,
  input wire logic i_standstill,
  input wire logic i_step,
  input wire logic [31:0] i_encoder_pos,
  // motion outputs
  output logic o_move,
  output logic o_dir_pos,
  output logic [15:0] o_speed,
  output logic o_pos_load,
  output logic [31:0] o_pos_load_value,
  output logic o_busy,
  output logic o_ref_ok
);

  // ----------------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------------
  logic [31:0] edge_home_q;
  logic [31:0] edge_idx_q;
  logic [31:0] pos_set_q;
  logic [7:0] method_q;
  logic [15:0] search_spd_q;
  logic [15:0] leave_spd_q;
  logic [31:0] home_pos_q;
  logic [15:0] max_ramp_q;
  logic [31:0] ref_pos_q;
  logic [31:0] edge_pos_q;
  logic ack_q;
  logic ref_ok_q;
  logic load_q;
  logic [31:0] load_val_q;
  logic dir_q;
  logic seen_q;
  hms_pkg::hms_state_type state_q;
  hms_pkg::hms_state_type state_d;
  logic [31:0] dist_cnt;

  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] hi);
    if (v[31:16] != 16'h0000 || v[15:0] > hi) begin
      clamp16 = hi;
    end else if (v[15:0] < hms_pkg::SPD_MIN) begin
      clamp16 = hms_pkg::SPD_MIN;
    end else begin
      clamp16 = v[15:0];
    end
  endfunction

  wire wr_edge_home = i_par_wr && i_par_addr == hms_pkg::ADDR_EDGE_HOME;
  wire wr_pos_set = i_par_wr && i_par_addr == hms_pkg::ADDR_POS_SET;
  wire wr_method = i_par_wr && i_par_addr == hms_pkg::ADDR_METHOD;
  wire wr_search = i_par_wr && i_par_addr == hms_pkg::ADDR_SEARCH_SPD;
  wire wr_leave = i_par_wr && i_par_addr == hms_pkg::ADDR_LEAVE_SPD;
  wire wr_home = i_par_wr && i_par_addr == hms_pkg::ADDR_HOME_POS;
  wire wr_ramp = i_par_wr && i_par_addr == hms_pkg::ADDR_MAX_RAMP;
  wire edge_ok = i_par_wdata >= hms_pkg::EDGE_HOME_MIN && i_par_wdata <= hms_pkg::EDGE_HOME_MAX;

  // ----------------------------------------------------------------
  // method decode
  // ----------------------------------------------------------------
  wire is_neg_lim = method_q == hms_pkg::M_NEG_LIMIT;
  wire is_pos_lim_idx = method_q == hms_pkg::M_POS_LIMIT_IDX;
  wire is_ref_dist = method_q >= hms_pkg::M_REF_DIST_LO && method_q <= hms_pkg::M_REF_DIST_HI;
  wire is_ref_idx = method_q >= hms_pkg::M_REF_IDX_LO && method_q <= hms_pkg::M_REF_IDX_HI;
  wire is_idx_only = method_q == hms_pkg::M_IDX_NEG || method_q == hms_pkg::M_IDX_POS;
  wire uses_ref = is_ref_dist || is_ref_idx;
  wire uses_index = is_pos_lim_idx || is_ref_idx || is_idx_only;
  wire method_ok = is_neg_lim || is_pos_lim_idx || uses_ref || is_idx_only;
  // odd codes in each group leave the edge towards positive
  wire leave_pos = uses_ref ? method_q[0] : is_neg_lim;
  wire on_switch = uses_ref ? i_ref_switch :
                   (is_neg_lim ? i_negative_limit_input : i_positive_limit_input);
  wire [15:0] search_eff = search_spd_q > max_ramp_q ? max_ramp_q : search_spd_q;
  wire [15:0] leave_eff = leave_spd_q > max_ramp_q ? max_ramp_q : leave_spd_q;

  // ----------------------------------------------------------------
  // parameter port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      edge_home_q <= hms_pkg::EDGE_HOME_RST;
      pos_set_q <= 32'h0000_0000;
      method_q <= 8'h00;
      search_spd_q <= hms_pkg::SEARCH_SPD_RST;
      leave_spd_q <= hms_pkg::LEAVE_SPD_RST;
      home_pos_q <= 32'h0000_0000;
      max_ramp_q <= hms_pkg::MAX_RAMP_RST;
    end else begin
      if (wr_edge_home && edge_ok) begin
        edge_home_q <= i_par_wdata;
      end
      if (wr_pos_set) begin
        pos_set_q <= i_par_wdata;
      end
      if (wr_method) begin
        method_q <= i_par_wdata[7:0];
      end
      if (wr_search) begin
        search_spd_q <= clamp16(i_par_wdata, hms_pkg::SEARCH_SPD_MAX);
      end
      if (wr_leave) begin
        leave_spd_q <= clamp16(i_par_wdata, hms_pkg::LEAVE_SPD_MAX);
      end
      if (wr_home) begin
        home_pos_q <= i_par_wdata;
      end
      if (wr_ramp) begin
        max_ramp_q <= clamp16(i_par_wdata, hms_pkg::SEARCH_SPD_MAX);
      end
    end
  end

  always_comb begin
    case (i_par_addr)
      hms_pkg::ADDR_REF_POS: o_par_rdata = ref_pos_q;
      hms_pkg::ADDR_EDGE_HOME: o_par_rdata = edge_home_q;
      hms_pkg::ADDR_EDGE_IDX: o_par_rdata = edge_idx_q;
      hms_pkg::ADDR_POS_SET: o_par_rdata = pos_set_q;
      hms_pkg::ADDR_METHOD: o_par_rdata = {24'h000000, method_q};
      hms_pkg::ADDR_SEARCH_SPD: o_par_rdata = {16'h0000, search_spd_q};
      hms_pkg::ADDR_LEAVE_SPD: o_par_rdata = {16'h0000, leave_spd_q};
      hms_pkg::ADDR_HOME_POS: o_par_rdata = home_pos_q;
      hms_pkg::ADDR_MAX_RAMP: o_par_rdata = {16'h0000, max_ramp_q};
      hms_pkg::ADDR_STATUS: o_par_rdata = {29'h0000000, o_busy, method_ok, ref_ok_q};
      default: o_par_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_par_wr || i_par_rd;
    end
  end
  assign o_par_ack = ack_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire idx_edge = i_index_pulse;
  // stop is two cycles behind the last step; the drive must not step
  // again within two cycles or the final position overshoots
  wire offset_done = dist_cnt >= edge_home_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      hms_pkg::ST_IDLE: begin
        if (i_start && method_ok) begin
          state_d = is_idx_only ? hms_pkg::ST_INDEX : hms_pkg::ST_SEARCH;
        end
      end
      hms_pkg::ST_SEARCH: begin
        if (uses_ref && seen_q && !on_switch) begin
          state_d = hms_pkg::ST_RETURN;
        end else if (on_switch) begin
          state_d = hms_pkg::ST_EDGE;
        end
      end
      hms_pkg::ST_RETURN: begin
        if (on_switch) begin
          state_d = hms_pkg::ST_EDGE;
        end
      end
      hms_pkg::ST_EDGE: begin
        if (!on_switch) begin
          state_d = uses_index ? hms_pkg::ST_INDEX : hms_pkg::ST_OFFSET;
        end
      end
      hms_pkg::ST_OFFSET: begin
        if (offset_done) begin
          state_d = hms_pkg::ST_DONE;
        end
      end
      hms_pkg::ST_INDEX: begin
        if (idx_edge) begin
          state_d = hms_pkg::ST_DONE;
        end
      end
      hms_pkg::ST_DONE: state_d = hms_pkg::ST_IDLE;
      default: state_d = hms_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= hms_pkg::ST_IDLE;
      dir_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == hms_pkg::ST_IDLE && state_d != hms_pkg::ST_IDLE) begin
        dir_q <= is_idx_only ? method_q == hms_pkg::M_IDX_POS :
                 (is_pos_lim_idx ? 1'b1 : 1'b0);
        seen_q <= 1'b0;
      end else if (state_d == hms_pkg::ST_RETURN && state_q == hms_pkg::ST_SEARCH) begin
        dir_q <= ~dir_q;
      end else if (state_d == hms_pkg::ST_EDGE && state_q != hms_pkg::ST_EDGE) begin
        dir_q <= leave_pos;
      end
      if (on_switch) begin
        seen_q <= 1'b1;
      end
    end
  end

  hms_offset_counter u_offset (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(state_q != hms_pkg::ST_OFFSET && state_q != hms_pkg::ST_INDEX),
    .i_step(i_step),
    .o_count(dist_cnt)
  );

  // ----------------------------------------------------------------
  // position handling
  // ----------------------------------------------------------------
  // standstill only
  wire set_now = wr_pos_set && i_standstill && state_q == hms_pkg::ST_IDLE;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_ok_q <= 1'b0;
      load_q <= 1'b0;
      load_val_q <= 32'h0000_0000;
      edge_pos_q <= 32'h0000_0000;
      edge_idx_q <= 32'h0000_0000;
      ref_pos_q <= 32'h0000_0000;
    end else begin
      load_q <= 1'b0;
      ref_pos_q <= i_encoder_pos;
      if (state_q == hms_pkg::ST_EDGE && !on_switch) begin
        edge_pos_q <= i_encoder_pos;
      end
      if (state_q == hms_pkg::ST_INDEX && idx_edge) begin
        edge_idx_q <= i_encoder_pos - edge_pos_q;
      end
      // position setting, error kept by loading actual only
      if (set_now) begin
        load_q <= 1'b1;
        load_val_q <= i_par_wdata;
      end else if (state_q == hms_pkg::ST_DONE) begin
        load_q <= 1'b1;
        load_val_q <= home_pos_q;
      end
      if (state_q == hms_pkg::ST_DONE || set_now) begin
        ref_ok_q <= 1'b1;
      end else if (i_ref_lost) begin
        ref_ok_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire moving = state_q != hms_pkg::ST_IDLE && state_q != hms_pkg::ST_DONE;
  assign o_move = moving;
  assign o_dir_pos = dir_q;
  assign o_speed = !moving ? 16'h0000 :
                   (state_q == hms_pkg::ST_SEARCH ? search_eff : leave_eff);
  assign o_pos_load = load_q;
  assign o_pos_load_value = load_val_q;
  assign o_busy = moving;
  assign o_ref_ok = ref_ok_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_bad_method;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == hms_pkg::ST_IDLE && i_start && !method_ok) |=> !o_move;
  endproperty
  a_bad_method: assert property (p_bad_method) else $error("bad method moved");

  property p_search_speed;
    @(posedge i_clock) disable iff (i_rst)
      state_q == hms_pkg::ST_SEARCH |-> o_speed == search_eff;
  endproperty
  a_search_speed: assert property (p_search_speed) else $error("search speed wrong");

  property p_leave_speed;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == hms_pkg::ST_EDGE || state_q == hms_pkg::ST_OFFSET) |-> o_speed == leave_eff;
  endproperty
  a_leave_speed: assert property (p_leave_speed) else $error("leave speed wrong");

  property p_clamp;
    @(posedge i_clock) disable iff (i_rst) o_speed <= max_ramp_q;
  endproperty
  a_clamp: assert property (p_clamp) else $error("speed above ramp max");

  property p_done_load;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == hms_pkg::ST_DONE && !set_now) |=> o_pos_load && o_pos_load_value == $past(home_pos_q) && o_ref_ok;
  endproperty
  a_done_load: assert property (p_done_load) else $error("home load missing");

  property p_set_pos;
    @(posedge i_clock) disable iff (i_rst)
      set_now |=> o_pos_load && o_pos_load_value == $past(i_par_wdata);
  endproperty
  a_set_pos: assert property (p_set_pos) else $error("position set missing");

  property p_set_moving;
    @(posedge i_clock) disable iff (i_rst)
      (wr_pos_set && !i_standstill && state_q != hms_pkg::ST_DONE) |=> !o_pos_load;
  endproperty
  a_set_moving: assert property (p_set_moving) else $error("set while moving");

  sequence s_idx_start;
    state_q == hms_pkg::ST_IDLE && i_start && method_ok && is_idx_only;
  endsequence
  property p_idx_direct;
    @(posedge i_clock) disable iff (i_rst)
      s_idx_start |=> state_q == hms_pkg::ST_INDEX && o_speed == leave_eff;
  endproperty
  a_idx_direct: assert property (p_idx_direct) else $error("index homing not direct");

  property p_ref_first_neg;
    @(posedge i_clock) disable iff (i_rst)
      (state_q == hms_pkg::ST_IDLE && i_start && uses_ref) |=> !o_dir_pos;
  endproperty
  a_ref_first_neg: assert property (p_ref_first_neg) else $error("first move not negative");

  property p_edge_range;
    @(posedge i_clock) disable iff (i_rst)
      edge_home_q >= hms_pkg::EDGE_HOME_MIN && edge_home_q <= hms_pkg::EDGE_HOME_MAX;
  endproperty
  a_edge_range: assert property (p_edge_range) else $error("edge distance out of range");

endmodule

// ### verification/hms_motor_model.sv
/*
  Far-side model: motor with encoder, limit switches, reference switch
  and index pulse. Assumes the sequencer's move and direction outputs
  as commands; one step per user unit, switches active high.
*/
module hms_motor_model #(
  parameter int NEG_AT = -200,
  parameter int POS_AT = 400,
  parameter int REF_LO = 100,
  parameter int REF_HI = 101,
  parameter int IDX_P = 64
) (
  // clock and commands
  input wire logic i_clock,
  input wire logic i_move,
  input wire logic i_dir_pos,
  input wire logic i_slow,
  input wire logic i_place,
  input wire logic [31:0] i_place_pos,
  // feedback
  output logic o_step,
  output logic o_index,
  output logic o_standstill,
  output logic o_pos_limit,
  output logic o_neg_limit,
  output logic o_ref_sw,
  output logic [31:0] o_pos
);
  timeunit 1ns;
  timeprecision 100ps;
  int pos = 0;
  int gap = 0;
  int np;
  assign o_pos = pos;
  assign o_standstill = !i_move && !o_step;
  assign o_neg_limit = (pos <= NEG_AT);
  assign o_pos_limit = (pos >= POS_AT);
  assign o_ref_sw = (pos >= REF_LO) && (pos <= REF_HI);
  // gap of two cycles at least, so a stop command is seen before the next step
  always @(posedge i_clock) begin
    o_step <= 1'b0;
    o_index <= 1'b0;
    if (i_place) begin
      pos <= $signed(i_place_pos);
    end else if (gap > 0) begin
      gap <= gap - 1;
    end else if (i_move) begin
      np = i_dir_pos ? pos + 1 : pos - 1;
      pos <= np;
      o_step <= 1'b1;
      o_index <= (np % IDX_P == 0);
      gap <= i_slow ? 4 : 2;
    end
  end
endmodule

// ### verification/hms_homing_sequencer_bench.sv
/*
  Self-checking bench for the homing sequencer against a motor model.
  Assumes the package's addresses and the model's switch layout.
*/
module hms_homing_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------
  // signals
  // ------------
  localparam int NEG_AT = -200;
  localparam int POS_AT = 400;
  localparam int REF_LO = 100;
  localparam int REF_HI = 101;
  localparam int IDX_P = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic par_wr = 1'b0;
  logic par_rd = 1'b0;
  logic start = 1'b0;
  logic ref_lost = 1'b0;
  logic slow = 1'b0;
  logic place = 1'b0;
  logic [15:0] par_addr = 16'h0000;
  logic [31:0] par_wdata = 32'h0000_0000;
  logic [31:0] place_pos = 32'h0000_0000;
  logic [31:0] par_rdata, enc_pos, load_val, rd_v;
  logic [15:0] speed;
  logic par_ack, plim, nlim, refsw, idx, still, step, move, dir_pos, pos_load, busy, ref_ok;
  logic [31:0] exp_q[$];
  logic [7:0] codes[12] = '{8'h11, 8'h02, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                            8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h21, 8'h22};
  int error_cnt = 0;
  int checks_done = 0;
  int edge_d = 24;
  int srch = 600;
  int leave = 60;
  int ramp = 13200;
  int home_v, sp_bad, sw_sel, e, f, s;
  bit dir0, hm_on, seen;

  initial forever #20 clk = ~clk;

  hms_homing_sequencer i_dut (
    .i_clock(clk), .i_rst(rst), .i_par_wr(par_wr), .i_par_rd(par_rd),
    .i_par_addr(par_addr), .i_par_wdata(par_wdata), .o_par_rdata(par_rdata),
    .o_par_ack(par_ack), .i_start(start), .i_ref_lost(ref_lost),
    .i_positive_limit_input(plim), .i_negative_limit_input(nlim),
    .i_ref_switch(refsw), .i_index_pulse(idx), .i_standstill(still), .i_step(step),
    .i_encoder_pos(enc_pos), .o_move(move), .o_dir_pos(dir_pos), .o_speed(speed),
    .o_pos_load(pos_load), .o_pos_load_value(load_val), .o_busy(busy), .o_ref_ok(ref_ok)
  );
  hms_motor_model #(.NEG_AT(NEG_AT), .POS_AT(POS_AT), .REF_LO(REF_LO), .REF_HI(REF_HI),
    .IDX_P(IDX_P)) i_motor (
    .i_clock(clk), .i_move(move), .i_dir_pos(dir_pos), .i_slow(slow), .i_place(place),
    .i_place_pos(place_pos), .o_step(step), .o_index(idx), .o_standstill(still),
    .o_pos_limit(plim), .o_neg_limit(nlim), .o_ref_sw(refsw), .o_pos(enc_pos)
  );

  // ------------
  // tasks
  // ------------
  task automatic check(input string w, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", w, x, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    par_wr = 1'b1;
    par_addr = a;
    par_wdata = d;
    @(posedge clk);
    #1 par_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rdc(input string w, input logic [15:0] a, input logic [31:0] x);
    par_rd = 1'b1;
    par_addr = a;
    @(negedge clk);
    rd_v = par_rdata;
    @(posedge clk);
    #1 par_rd = 1'b0;
    check("par_ack", 1, par_ack);
    check(w, x, rd_v);
    @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] sp(input int v);
    return 16'(v < ramp ? v : ramp);
  endfunction

  // edge, final and start positions per method code
  task automatic exp_of(input logic [7:0] c);
    s = (c == 8'h11) ? 0 : (c == 8'h02) ? 300 : 150;
    e = (c == 8'h11) ? NEG_AT + 1 : (c == 8'h02) ? POS_AT - 1 : c[0] ? REF_HI + 1 : REF_LO - 1;
    if (c > 8'h20) e = s;
    if (c == 8'h11 || c > 8'h1a && c < 8'h1f) begin
      f = (c[0] || c == 8'h11) ? e + edge_d : e - edge_d;
    end else begin
      f = (c[0] ^ (c > 8'h20)) ? (e / IDX_P + 1) * IDX_P : ((e - 1) / IDX_P) * IDX_P;
    end
  endtask

  task automatic home(input logic [7:0] c);
    int n;
    n = 0;
    place = 1'b1;
    place_pos = s;
    @(posedge clk);
    #1 place = 1'b0;
    wr(hms_pkg::ADDR_METHOD, {24'h000000, c});
    home_v = $urandom;
    wr(hms_pkg::ADDR_HOME_POS, home_v);
    exp_q.push_back(home_v);
    sw_sel = (c == 8'h11) ? 1 : (c == 8'h02) ? 2 : (c < 8'h1f) ? 3 : 0;
    seen = (sw_sel == 0);
    dir0 = (c == 8'h02 || c == 8'h22);
    sp_bad = 0;
    hm_on = 1'b1;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (6) @(posedge clk);
    #1 wr(hms_pkg::ADDR_POS_SET, home_v + 1);
    while (exp_q.size() > 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    #1 hm_on = 1'b0;
    check("homing_pending", 0, exp_q.size());
    check("final_pos", f, enc_pos);
    check("ref_ok_home", 1, ref_ok);
    check("speed_dir_faults", 0, sp_bad);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------
  // monitor: every load against the queue; speed each moving homing cycle, direction until the switch is seen
  // ------------
  always @(negedge clk) begin
    if (!rst && pos_load === 1'b1) begin
      if (exp_q.size() == 0) check("spurious_load", 0, 1);
      else check("load_value", exp_q.pop_front(), load_val);
    end
    if (hm_on && move === 1'b1) begin
      if (speed !== (seen ? sp(leave) : sp(srch))) sp_bad++;
      if (!seen && dir_pos !== dir0) sp_bad++;
      if ((sw_sel == 1 && nlim === 1'b1) || (sw_sel == 2 && plim === 1'b1) ||
          (sw_sel == 3 && refsw === 1'b1)) begin
        seen = 1'b1;
      end
    end
  end

  // ------------
  // main sequence and watchdog
  // ------------
  initial begin
    void'($urandom(38009));
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    check("ref_ok_rst", 0, ref_ok);
    rdc("edge_home_rst", hms_pkg::ADDR_EDGE_HOME, 32'h0000_0018);
    rdc("search_rst", hms_pkg::ADDR_SEARCH_SPD, {16'h0000, hms_pkg::SEARCH_SPD_RST});
    rdc("leave_rst", hms_pkg::ADDR_LEAVE_SPD, {16'h0000, hms_pkg::LEAVE_SPD_RST});
    rdc("unmapped", 16'h0004, 32'h0000_0000);
    wr(hms_pkg::ADDR_EDGE_HOME, 32'h0000_0000);
    wr(hms_pkg::ADDR_EDGE_HOME, 32'h8000_0000);
    rdc("edge_home_range", hms_pkg::ADDR_EDGE_HOME, 32'h0000_0018);
    wr(hms_pkg::ADDR_EDGE_HOME, 32'h7fff_ffff);
    rdc("edge_home_max", hms_pkg::ADDR_EDGE_HOME, 32'h7fff_ffff);
    wr(hms_pkg::ADDR_SEARCH_SPD, 32'h0000_ffff);
    srch = 13200;
    rdc("search_clamp", hms_pkg::ADDR_SEARCH_SPD, 32'h0000_3390);
    ramp = 500;
    wr(hms_pkg::ADDR_MAX_RAMP, ramp);
    leave = 1 + $urandom_range(2999);
    wr(hms_pkg::ADDR_LEAVE_SPD, leave);
    for (int i = 0; i < 3; i++) begin
      home_v = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h7fff_ffff : $urandom;
      exp_q.push_back(home_v);
      wr(hms_pkg::ADDR_POS_SET, home_v);
      check("set_pending", 0, exp_q.size());
      check("ref_ok_set", 1, ref_ok);
    end
    ref_lost = 1'b1;
    @(posedge clk);
    #1 ref_lost = 1'b0;
    check("ref_ok_lost", 0, ref_ok);
    wr(hms_pkg::ADDR_METHOD, 32'h0000_0005);
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    check("bad_method_busy", 0, busy);
    for (int i = 0; i < 12; i++) begin
      slow = i[0];
      if (i == 6) begin
        ramp = 13200;
        srch = 1 + $urandom_range(13199);
        wr(hms_pkg::ADDR_MAX_RAMP, ramp);
        wr(hms_pkg::ADDR_SEARCH_SPD, srch);
      end
      edge_d = 1 + $urandom_range(15);
      wr(hms_pkg::ADDR_EDGE_HOME, edge_d);
      exp_of(codes[i]);
      home(codes[i]);
      if (codes[i] < 8'h0f) begin
        wr(hms_pkg::ADDR_EDGE_IDX, $urandom);
        rdc("edge_to_index", hms_pkg::ADDR_EDGE_IDX, f - e);
      end
    end
    tally_and_finish();
  end

  initial begin
    #1000000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
